// file: include/ram_modes_pkg.sv
package ram_modes_pkg;

  // storage geometry: 512 words of 8 bits is one mid_size_ram_block of 4K bits
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int DEPTH = 512;

  // largest single-port memory when the block is split in two
  localparam int HALF_BITS_MAX = 2048;

  // address bit that picks the half in the split single-port arrangement
  localparam int HALF_SEL_BIT = ADDR_W - 1;

  // clocking arrangements; Gray codes along the listed order
  typedef enum logic [2:0] {
    MODE_TDP_INDEP = 3'h0,
    MODE_TDP_IO = 3'h1,
    MODE_SDP_IO = 3'h3,
    MODE_SDP_RW = 3'h2,
    MODE_SINGLE = 3'h6,
    MODE_DUAL_SINGLE = 3'h7
  } mode_t;

  // register groups of the block
  typedef enum logic [1:0] {
    GRP_IN_A = 2'h0,
    GRP_OUT_A = 2'h1,
    GRP_OUT_B = 2'h3,
    GRP_IN_B = 2'h2
  } group_t;

  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;

endpackage

// file: include/ram_array_if.sv
`timescale 1ns/1ps
// carries one access per port from the port registers to the storage array
interface ram_array_if #(
  parameter int DW = 8,
  parameter int AW = 9
);
  logic enable;
  logic we_a;
  logic re_a;
  logic [AW-1:0] addr_a;
  logic [DW-1:0] wdata_a;
  logic [DW-1:0] rdata_a;
  logic we_b;
  logic re_b;
  logic [AW-1:0] addr_b;
  logic [DW-1:0] wdata_b;
  logic [DW-1:0] rdata_b;

  modport ctrl (
    output enable, we_a, re_a, addr_a, wdata_a, we_b, re_b, addr_b, wdata_b,
    input rdata_a, rdata_b
  );
  modport store (
    input enable, we_a, re_a, addr_a, wdata_a, we_b, re_b, addr_b, wdata_b,
    output rdata_a, rdata_b
  );
endinterface

// file: src/ram_array.sv
`timescale 1ns/1ps
// storage array with a registered read word per port; the array itself
// has no reset so clears never touch stored contents
module ram_array #(
  parameter int DW = ram_modes_pkg::DATA_W,
  parameter int AW = ram_modes_pkg::ADDR_W,
  parameter int WORDS = ram_modes_pkg::DEPTH
) (
  input wire logic clk,
  ram_array_if.store bus
);

  logic [DW-1:0] mem [WORDS];

  // writes; when both ports hit one word in one cycle port A lands last
  always_ff @(posedge clk) begin
    if (bus.enable) begin
      if (bus.we_b) begin
        mem[bus.addr_b] <= bus.wdata_b;
      end
      if (bus.we_a) begin
        mem[bus.addr_a] <= bus.wdata_a;
      end
    end
  end

  // read words are registered: old data is returned on a same-word write
  always_ff @(posedge clk) begin
    if (bus.enable && bus.re_a) begin
      bus.rdata_a <= mem[bus.addr_a];
    end
  end

  always_ff @(posedge clk) begin
    if (bus.enable && bus.re_b) begin
      bus.rdata_b <= mem[bus.addr_b];
    end
  end

endmodule // ram_array

// file: src/ram_clock_modes.sv
`timescale 1ns/1ps
// What this block does
// R1 - input/output clocking selectable in true and simple dual-port use
// R2 - per port, data, write strobe and location captured on one input clock
// R3 - per port, read-data output registers run on a separate second clock
// R4 - input and output groups each get own clock enable and clear
// R5 - true dual-port input/output clocking: every register has an asynchronous clear
// R6 - simple dual-port: read strobe register lacks clear, all others have one
// R7 - read/write clocking for simple dual-port, at most two clocks
// R8 - write clock registers write data, write location and write strobe
// R9 - read clock registers read location, read strobe and read-data output
// R10 - read and write clocks get own enables and separate clears
// R11 - single-port use with one shared location input
// R12 - block may hold two single-port memories, each at most 2K bits
// R13 - independent clocking: one clock per port drives all its registers
// R14 - clears reset port registers only, never stored array contents
module ram_clock_modes #(
  parameter int DW = ram_modes_pkg::DATA_W,
  parameter int AW = ram_modes_pkg::ADDR_W,
  parameter int WORDS = ram_modes_pkg::DEPTH
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  input wire ram_modes_pkg::mode_t MODE,
  input wire logic TICK0,
  input wire logic TICK1,
  input wire logic [DW-1:0] A_DATA_IN,
  input wire logic [AW-1:0] A_ADDR,
  input wire logic A_WREN,
  input wire logic A_RDEN,
  input wire logic A_IN_ENA,
  input wire logic A_OUT_ENA,
  input wire logic A_IN_CLR,
  input wire logic A_OUT_CLR,
  input wire logic [DW-1:0] B_DATA_IN,
  input wire logic [AW-1:0] B_ADDR,
  input wire logic B_WREN,
  input wire logic B_RDEN,
  input wire logic B_IN_ENA,
  input wire logic B_OUT_ENA,
  input wire logic B_IN_CLR,
  input wire logic B_OUT_CLR,
  output logic [DW-1:0] A_DATA_OUT,
  output logic [DW-1:0] B_DATA_OUT
);

  // which of the two block clocks (tick strobes) steps a register group
  function automatic logic group_tick(
    input ram_modes_pkg::mode_t mode,
    input ram_modes_pkg::group_t grp,
    input logic t0,
    input logic t1
  );
    logic res;
    res = t0;
    case (mode)
      ram_modes_pkg::MODE_TDP_INDEP,
      ram_modes_pkg::MODE_DUAL_SINGLE: begin
        // one clock per port for all its registers
        res = (grp == ram_modes_pkg::GRP_IN_A || grp == ram_modes_pkg::GRP_OUT_A) ? t0 : t1; // R13
      end
      ram_modes_pkg::MODE_TDP_IO, // R1
      ram_modes_pkg::MODE_SDP_IO: begin
        // inputs on the first clock, outputs on the second
        res = (grp == ram_modes_pkg::GRP_IN_A || grp == ram_modes_pkg::GRP_IN_B) ? t0 : t1; // R2 R3
      end
      ram_modes_pkg::MODE_SDP_RW: begin
        // write side on the first clock, whole read side on the second
        res = (grp == ram_modes_pkg::GRP_IN_A) ? t0 : t1; // R7 R8 R9
      end
      ram_modes_pkg::MODE_SINGLE: begin
        res = t0;
      end
      default: begin
        res = t0;
      end
    endcase
    return res;
  endfunction

  // true when the output group of a port borrows the enable and clear of its
  // input group because both groups share one clock in that mode
  function automatic logic out_shares_in(
    input ram_modes_pkg::mode_t mode,
    input logic port_b
  );
    logic res;
    res = 1'b0;
    case (mode)
      ram_modes_pkg::MODE_TDP_INDEP,
      ram_modes_pkg::MODE_DUAL_SINGLE,
      ram_modes_pkg::MODE_SINGLE: begin
        res = 1'b1;
      end
      ram_modes_pkg::MODE_SDP_RW: begin
        res = port_b; // read clock owns one enable and one clear R10
      end
      default: begin
        res = 1'b0; // R4
      end
    endcase
    return res;
  endfunction

  function automatic logic is_simple_dual(input ram_modes_pkg::mode_t mode);
    return (mode == ram_modes_pkg::MODE_SDP_IO) || (mode == ram_modes_pkg::MODE_SDP_RW);
  endfunction

  // steer the top address bit so each half stays a separate 2K-bit memory
  function automatic logic [AW-1:0] half_addr(
    input ram_modes_pkg::mode_t mode,
    input logic [AW-1:0] addr,
    input logic upper
  );
    logic [AW-1:0] res;
    res = addr;
    if (mode == ram_modes_pkg::MODE_DUAL_SINGLE) begin
      res[ram_modes_pkg::HALF_SEL_BIT] = upper; // R12
    end
    return res;
  endfunction

  logic share_a;
  logic share_b;
  logic sdp;
  logic tick_in_a;
  logic tick_out_a;
  logic tick_in_b;
  logic tick_out_b;
  logic ena_out_a;
  logic ena_out_b;
  logic clr_out_a;
  logic clr_out_b;
  logic in_a_rst_n;
  logic in_b_rst_n;
  logic out_a_rst_n;
  logic out_b_rst_n;
  logic rden_b_rst_n;
  logic cap_a;
  logic cap_b;
  logic out_load_a;
  logic out_load_b;

  // group clocking; MODE is a configuration level and must stay static
  // while any clear is released, since it feeds the clear steering
  assign sdp = is_simple_dual(MODE);
  assign share_a = out_shares_in(MODE, 1'b0);
  assign share_b = out_shares_in(MODE, 1'b1);
  assign tick_in_a = group_tick(MODE, ram_modes_pkg::GRP_IN_A, TICK0, TICK1);
  assign tick_out_a = group_tick(MODE, ram_modes_pkg::GRP_OUT_A, TICK0, TICK1);
  assign tick_in_b = group_tick(MODE, ram_modes_pkg::GRP_IN_B, TICK0, TICK1);
  assign tick_out_b = group_tick(MODE, ram_modes_pkg::GRP_OUT_B, TICK0, TICK1);
  assign ena_out_a = share_a ? A_IN_ENA : A_OUT_ENA; // R4 R10
  assign ena_out_b = share_b ? B_IN_ENA : B_OUT_ENA; // R4 R10
  assign clr_out_a = share_a ? A_IN_CLR : A_OUT_CLR; // R4 R10
  assign clr_out_b = share_b ? B_IN_CLR : B_OUT_CLR; // R4 R10

  // per-group asynchronous clears merged with the block reset
  assign in_a_rst_n = RESETN & ~A_IN_CLR; // R5
  assign in_b_rst_n = RESETN & ~B_IN_CLR; // R5
  assign out_a_rst_n = RESETN & ~clr_out_a; // R5
  assign out_b_rst_n = RESETN & ~clr_out_b; // R5
  // read strobe register of port B ignores its clear in simple dual-port
  assign rden_b_rst_n = RESETN & ~(B_IN_CLR & ~sdp); // R6

  assign cap_a = CE & tick_in_a & A_IN_ENA;
  assign cap_b = CE & tick_in_b & B_IN_ENA;
  assign out_load_a = CE & tick_out_a & ena_out_a;
  assign out_load_b = CE & tick_out_b & ena_out_b;

  logic [AW-1:0] addr_a;
  logic [DW-1:0] wdata_a;
  logic wren_a;
  logic rden_a;
  logic issue_a;
  logic [AW-1:0] addr_b;
  logic [DW-1:0] wdata_b;
  logic wren_b;
  logic rden_b;
  logic issue_b;

  // port A input group: data, strobes and location on one clock
  always_ff @(posedge CLOCK or negedge in_a_rst_n) begin
    if (!in_a_rst_n) begin
      addr_a <= ram_modes_pkg::ADDR_RESET;
      wdata_a <= ram_modes_pkg::DATA_RESET;
      wren_a <= 1'b0;
      rden_a <= 1'b0;
    end else if (cap_a) begin
      addr_a <= half_addr(MODE, A_ADDR, 1'b0); // R2 R8 R11 R12
      wdata_a <= A_DATA_IN; // R2 R8
      wren_a <= A_WREN; // R2 R8
      rden_a <= A_RDEN & ~sdp; // write-only port in simple dual-port
    end
  end

  // port A access pulse: one array access per capture
  always_ff @(posedge CLOCK or negedge in_a_rst_n) begin
    if (!in_a_rst_n) begin
      issue_a <= 1'b0;
    end else if (CE) begin
      issue_a <= cap_a;
    end
  end

  // port B location and data; only its read strobe escapes the clear below, in simple dual-port
  always_ff @(posedge CLOCK or negedge in_b_rst_n) begin
    if (!in_b_rst_n) begin
      addr_b <= ram_modes_pkg::ADDR_RESET;
      wdata_b <= ram_modes_pkg::DATA_RESET;
      wren_b <= 1'b0;
    end else if (cap_b) begin
      addr_b <= half_addr(MODE, B_ADDR, 1'b1); // R9 R12
      wdata_b <= B_DATA_IN; // R2
      wren_b <= B_WREN & ~sdp; // read-only port in simple dual-port
    end
  end

  // port B read strobe register; cleared by B_IN_CLR in every mode but simple dual-port
  always_ff @(posedge CLOCK or negedge rden_b_rst_n) begin
    if (!rden_b_rst_n) begin
      rden_b <= 1'b0;
    end else if (cap_b) begin
      rden_b <= B_RDEN; // R6 R9
    end
  end

  // port B access pulse
  always_ff @(posedge CLOCK or negedge in_b_rst_n) begin
    if (!in_b_rst_n) begin
      issue_b <= 1'b0;
    end else if (CE) begin
      issue_b <= cap_b;
    end
  end

  // the array sits behind the port registers and has no clear of its own
  ram_array_if #(.DW(DW), .AW(AW)) arr ();

  logic port_b_used;

  // single-port use leaves port B idle so only one location input acts
  assign port_b_used = (MODE != ram_modes_pkg::MODE_SINGLE); // R11
  assign arr.enable = CE;
  assign arr.we_a = issue_a & wren_a;
  assign arr.re_a = issue_a & rden_a;
  assign arr.addr_a = addr_a;
  assign arr.wdata_a = wdata_a;
  assign arr.we_b = issue_b & wren_b & port_b_used;
  assign arr.re_b = issue_b & rden_b & port_b_used;
  assign arr.addr_b = addr_b;
  assign arr.wdata_b = wdata_b;

  ram_array #(.DW(DW), .AW(AW), .WORDS(WORDS)) store_u (
    .clk(CLOCK),
    .bus(arr.store)
  ); // R14

  // port A read-data output register on its output clock
  always_ff @(posedge CLOCK or negedge out_a_rst_n) begin
    if (!out_a_rst_n) begin
      A_DATA_OUT <= ram_modes_pkg::DATA_RESET;
    end else if (out_load_a) begin
      A_DATA_OUT <= arr.rdata_a; // R3
    end
  end

  // port B read-data output register; the read clock in read/write mode
  always_ff @(posedge CLOCK or negedge out_b_rst_n) begin
    if (!out_b_rst_n) begin
      B_DATA_OUT <= ram_modes_pkg::DATA_RESET;
    end else if (out_load_b) begin
      B_DATA_OUT <= arr.rdata_b; // R3 R9
    end
  end

endmodule // ram_clock_modes

// file: sim/fabric_ticks.sv
`timescale 1ns/1ps
// fabric side that steps the two register groups; clocks are tick strobes
module fabric_ticks (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  output logic tick0,
  output logic tick1
);
  // second clock at half rate when slow, so wrong clock steering shows
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick0 <= 1'b0;
      tick1 <= 1'b0;
    end else begin
      tick0 <= 1'b1;
      tick1 <= slow ? ~tick1 : 1'b1;
    end
  end
endmodule // fabric_ticks

// file: sim/ram_clock_modes_properties.sv
`timescale 1ns/1ps
// port-side checks; both clocks arrive as tick strobes on CLOCK
module ram_clock_modes_properties #(
  parameter int DW = ram_modes_pkg::DATA_W
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire ram_modes_pkg::mode_t MODE,
  input wire logic TICK1,
  input wire logic A_OUT_ENA,
  input wire logic A_IN_CLR,
  input wire logic A_OUT_CLR,
  input wire logic B_IN_CLR,
  input wire logic [DW-1:0] A_DATA_OUT,
  input wire logic [DW-1:0] B_DATA_OUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // no clear on either sample, so a move of the output can only be a load
  sequence a_io_quiet;
    MODE == ram_modes_pkg::MODE_TDP_IO && !A_IN_CLR && !A_OUT_CLR;
  endsequence
  sequence b_rd_quiet;
    MODE == ram_modes_pkg::MODE_SDP_RW && !B_IN_CLR;
  endsequence
  reset_zero_a: assert property ($rose(RESETN)
    |-> A_DATA_OUT == '0 && B_DATA_OUT == '0) else $error("output not zero after reset");
  out_clear_a: assert property (MODE == ram_modes_pkg::MODE_TDP_IO && A_OUT_CLR
    |-> A_DATA_OUT == '0) else $error("A output not cleared");
  out_ena_hold_a: assert property (a_io_quiet ##0 !A_OUT_ENA ##1 a_io_quiet
    |-> $stable(A_DATA_OUT)) else $error("A output moved while disabled");
  out_tick_hold_a: assert property (a_io_quiet ##0 !TICK1 ##1 a_io_quiet
    |-> $stable(A_DATA_OUT)) else $error("A output moved without its clock");
  indep_clear_a: assert property (MODE == ram_modes_pkg::MODE_TDP_INDEP && A_IN_CLR
    |-> A_DATA_OUT == '0) else $error("port A clear missed output");
  rd_clear_a: assert property (MODE == ram_modes_pkg::MODE_SDP_RW && B_IN_CLR
    |-> B_DATA_OUT == '0) else $error("read clear missed output");
  rd_tick_hold_a: assert property (b_rd_quiet ##0 !TICK1 ##1 b_rd_quiet
    |-> $stable(B_DATA_OUT)) else $error("read output moved without its clock");
  single_clear_a: assert property (MODE == ram_modes_pkg::MODE_SINGLE && A_IN_CLR
    |-> A_DATA_OUT == '0) else $error("single-port clear missed output");
endmodule // ram_clock_modes_properties

bind ram_clock_modes ram_clock_modes_properties #(.DW(DW)) props (.CLOCK, .RESETN, .MODE,
  .TICK1, .A_OUT_ENA, .A_IN_CLR, .A_OUT_CLR, .B_IN_CLR, .A_DATA_OUT, .B_DATA_OUT);

// file: sim/ram_clock_modes_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module ram_clock_modes_tb;
  logic CLOCK, RESETN, CE, TICK0, TICK1, slow;
  ram_modes_pkg::mode_t MODE;
  logic A_WREN, A_RDEN, B_WREN, B_RDEN;
  logic [8:0] A_ADDR, B_ADDR;
  logic [7:0] A_DATA_IN, B_DATA_IN, A_DATA_OUT, B_DATA_OUT;
  logic [3:0] ena, clr;
  int n_fail = 0;
  int num_checks = 0;

  ram_clock_modes dut (.CLOCK, .RESETN, .CE, .MODE, .TICK0, .TICK1, .A_DATA_IN, .A_ADDR,
    .A_WREN, .A_RDEN, .A_IN_ENA(ena[0]), .A_OUT_ENA(ena[1]), .A_IN_CLR(clr[0]),
    .A_OUT_CLR(clr[1]), .B_DATA_IN, .B_ADDR, .B_WREN, .B_RDEN, .B_IN_ENA(ena[2]),
    .B_OUT_ENA(ena[3]), .B_IN_CLR(clr[2]), .B_OUT_CLR(clr[3]), .A_DATA_OUT, .B_DATA_OUT);
  fabric_ticks fabric (.clk(CLOCK), .resetn(RESETN), .slow(slow), .tick0(TICK0),
    .tick1(TICK1));

  // 50 MHz
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one access, held until the port's input clock has stepped once
  task automatic acc(input logic b, input logic we, input logic re, input logic [8:0] ad,
    input logic [7:0] d);
    @(posedge CLOCK);
    if (b) begin
      {B_WREN, B_RDEN, B_ADDR, B_DATA_IN} <= {we, re, ad, d};
    end else begin
      {A_WREN, A_RDEN, A_ADDR, A_DATA_IN} <= {we, re, ad, d};
    end
    #1;
    while (!((b && MODE inside {ram_modes_pkg::MODE_TDP_INDEP, ram_modes_pkg::MODE_SDP_RW,
      ram_modes_pkg::MODE_DUAL_SINGLE}) ? TICK1 : TICK0)) begin
      @(posedge CLOCK);
      #1;
    end
    @(posedge CLOCK);
    {A_WREN, A_RDEN, B_WREN, B_RDEN} <= 4'h0;
  endtask

  // fixed wait, long enough for the new word; an old word equal to it still passes
  task automatic see(input logic b, input logic [7:0] e);
    repeat (4) @(posedge CLOCK);
    #1;
    `CHK(b ? B_DATA_OUT : A_DATA_OUT, e)
  endtask

  // a clear acts at once, without waiting for a clock
  task automatic clr_chk(input int i, input logic b);
    @(posedge CLOCK);
    clr[i] <= 1'b1;
    #1;
    `CHK(b ? B_DATA_OUT : A_DATA_OUT, 8'h00)
    @(posedge CLOCK);
    clr[i] <= 1'b0;
  endtask

  // mode only changes while idle, since it steers the clears
  task automatic go(input ram_modes_pkg::mode_t m);
    @(posedge CLOCK);
    MODE <= m;
  endtask

  // the whole walk takes about a hundred cycles
  initial begin
    repeat (5000) @(posedge CLOCK);
    n_fail++;
    complete_run();
  end

  // reset, then walk the clocking arrangements in turn
  initial begin
    {RESETN, CE, slow, ena, clr} = {3'b011, 4'hF, 4'h0};
    MODE = ram_modes_pkg::MODE_TDP_IO;
    {A_WREN, A_RDEN, B_WREN, B_RDEN, A_ADDR, B_ADDR} = 22'h000000;
    {A_DATA_IN, B_DATA_IN} = 16'h0000;
    repeat (3) @(posedge CLOCK);
    RESETN <= 1'b1;
    @(posedge CLOCK);
    #1;
    `CHK({A_DATA_OUT, B_DATA_OUT}, 16'h0000)
    acc(0, 1, 0, 9'h005, 8'h3C);
    acc(1, 1, 0, 9'h006, 8'hA5);
    acc(0, 0, 1, 9'h006, 8'h00);
    see(0, 8'hA5);
    acc(1, 0, 1, 9'h005, 8'h00);
    see(1, 8'h3C);
    @(posedge CLOCK);
    ena[1] <= 1'b0;
    acc(0, 0, 1, 9'h005, 8'h00);
    repeat (6) @(posedge CLOCK);
    #1;
    `CHK(A_DATA_OUT, 8'hA5)
    @(posedge CLOCK);
    ena[1] <= 1'b1;
    see(0, 8'h3C);
    clr_chk(1, 0);
    clr_chk(3, 1);
    acc(0, 0, 1, 9'h006, 8'h00);
    see(0, 8'hA5);
    go(ram_modes_pkg::MODE_SDP_IO);
    acc(1, 1, 0, 9'h005, 8'hFF);
    acc(0, 1, 0, 9'h010, 8'h5A);
    acc(1, 0, 1, 9'h005, 8'h00);
    see(1, 8'h3C);
    acc(1, 0, 1, 9'h010, 8'h00);
    see(1, 8'h5A);
    go(ram_modes_pkg::MODE_SDP_RW);
    acc(0, 1, 0, 9'h011, 8'hC3);
    acc(1, 0, 1, 9'h011, 8'h00);
    see(1, 8'hC3);
    clr_chk(2, 1);
    go(ram_modes_pkg::MODE_TDP_INDEP);
    clr_chk(0, 0);
    acc(1, 0, 1, 9'h010, 8'h00);
    see(1, 8'h5A);
    go(ram_modes_pkg::MODE_SINGLE);
    acc(0, 1, 0, 9'h020, 8'h77);
    acc(1, 1, 0, 9'h020, 8'hEE);
    acc(0, 0, 1, 9'h020, 8'h00);
    see(0, 8'h77);
    clr_chk(0, 0);
    go(ram_modes_pkg::MODE_DUAL_SINGLE);
    acc(0, 1, 0, 9'h003, 8'h11);
    acc(1, 1, 0, 9'h003, 8'h22);
    acc(0, 0, 1, 9'h003, 8'h00);
    see(0, 8'h11);
    acc(1, 0, 1, 9'h003, 8'h00);
    see(1, 8'h22);
    complete_run();
  end
endmodule // ram_clock_modes_tb
